// ### src/stripe_pkg.sv
package stripe_pkg;
  localparam int CLK_PERIOD_NS = 5;
  // handshake strobe timing on the host end, in ns
  localparam int CLEAR_LOW_NS = 500;
  localparam int STOP_LOW_NS = 12400;
  localparam int STROBE_HIGH_NS = 500;
  localparam int FLAG_CLEAR_NS = 2400;
  // latest auxiliary flag after wakeup, in ms
  localparam int AUX_TIMEOUT_MS = 3100;
  // least times round up
  localparam int CLEAR_LOW_CYC = (CLEAR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STOP_LOW_CYC = (STOP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLAG_CLEAR_CYC = (FLAG_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest time rounds down
  localparam int AUX_TIMEOUT_CYC = (AUX_TIMEOUT_MS * 1000) / CLK_PERIOD_NS * 1000;
  localparam int TRACKS = 3;
  localparam int BUF_BITS = 608;
  localparam int TIMER_W = 12;
  localparam logic LINE_IDLE = 1'b1;
endpackage

// ### src/stripe_link_if.sv
interface stripe_link_if;
  logic strobeN;
  logic dataLine;
  modport device (input strobeN, output dataLine);
  modport host (output strobeN, input dataLine);
endinterface

// ### src/sync_fall.sv
module sync_fall (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pinIn,
  output logic level,
  output logic fall
);
  logic s1_q, s2_q, s3_q;
  logic s1_d, s2_d, s3_d;

  always_comb begin
    s1_d = pinIn;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  assign level = s2_q;
  assign fall = s3_q & ~s2_q;
endmodule

// ### src/stripe_device.sv
// Summary of operation
// RULE1: host gives two strobe falls before preamble
// RULE2: without zeroes flag, sole data fall is aux
// RULE3: first strobe unacknowledged when no zeroes flag
// RULE4: second strobe unacknowledged once collection ended
// RULE5: aux before first strobe keeps data low
// RULE6: no rise after clear means aux occurred
// RULE7: stop strobe ignored until zeroes flag raised
// RULE8: each active track has 608-bit buffer
// RULE9: aux flag may come 3.1 s after wakeup
// RULE10: 75 bpi tracks may get random tail bits
// RULE11: host should stop before card end passes
// RULE12: on external switch host issues stop strobe
// RULE13: first strobe clears zeroes flag, data rises
// RULE14: aux on timeout, amplitude loss, or full
// RULE15: stop strobe ends collection within 10 us
// RULE16: one bit is low, zero bit high
module stripe_device #(
  parameter int TRACKS = stripe_pkg::TRACKS,
  parameter int BUF_BITS = stripe_pkg::BUF_BITS,
  parameter int AUX_TIMEOUT_CYC = stripe_pkg::AUX_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  stripe_link_if.device link,
  input wire logic [TRACKS-1:0] trackEn,
  input wire logic wakeup,
  input wire logic rearm,
  input wire logic zeroesDetect,
  input wire logic [TRACKS-1:0] ampLost,
  input wire logic [TRACKS-1:0] bitValid,
  input wire logic [TRACKS-1:0] bitIn,
  input wire logic [$clog2(TRACKS)-1:0] rdTrack,
  input wire logic [$clog2(BUF_BITS)-1:0] rdIdx,
  output logic rdBit,
  output logic collecting,
  output logic bufferReady,
  output logic [TRACKS-1:0] trackFull
);
  localparam int PW = $clog2(BUF_BITS + 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_COLLECT = 3'b010,
    ST_DONE = 3'b100
  } dev_state_e;

  dev_state_e state_q, state_d;
  logic zeroesPending_q, zeroesPending_d;
  logic zeroesSeen_q, zeroesSeen_d;
  logic auxSeen_q, auxSeen_d;
  logic [1:0] strobeCnt_q, strobeCnt_d;
  // wide enough for the full swipe timeout at the native clock, no prescaler
  logic [31:0] timer_q, timer_d;
  logic dataLine_q, dataLine_d;
  logic rdBit_q, rdBit_d;
  logic [TRACKS-1:0][BUF_BITS-1:0] buf_q, buf_d;
  logic [TRACKS-1:0][PW-1:0] ptr_q, ptr_d;
  logic strobeFall;
  logic [TRACKS-1:0] full;
  logic allFull, allLost, timeout, auxEvent, firstStrobe, secondStrobe;

  sync_fall u_strobe_sync (
    .mclk(mclk),
    .rst(rst),
    .pinIn(link.strobeN),
    .level(),
    .fall(strobeFall)
  );

  always_comb begin
    for (int t = 0; t < TRACKS; t++) begin
      full[t] = (ptr_q[t] == PW'(BUF_BITS)); // RULE8
    end
  end

  // only active tracks count towards the end-of-card conditions
  assign allFull = &(full | ~trackEn); // RULE14
  assign allLost = |trackEn & (&(ampLost | ~trackEn)); // RULE14
  assign timeout = (timer_q == 32'(AUX_TIMEOUT_CYC - 1)); // RULE9 RULE14
  assign auxEvent = (state_q == ST_COLLECT) & (allFull | allLost | timeout);
  assign firstStrobe = strobeFall & (strobeCnt_q == 2'h0);
  assign secondStrobe = strobeFall & (strobeCnt_q == 2'h1);

  always_comb begin
    state_d = state_q;
    zeroesPending_d = zeroesPending_q;
    zeroesSeen_d = zeroesSeen_q;
    auxSeen_d = auxSeen_q;
    strobeCnt_d = strobeCnt_q;
    timer_d = timer_q;
    case (state_q)
      ST_IDLE: begin
        if (wakeup) begin
          state_d = ST_COLLECT;
          timer_d = 32'h0;
          zeroesPending_d = 1'b0;
          zeroesSeen_d = 1'b0;
          auxSeen_d = 1'b0;
          strobeCnt_d = 2'h0;
        end
      end
      ST_COLLECT: begin
        timer_d = timer_q + 32'h1;
        if (auxEvent) begin
          auxSeen_d = 1'b1; // RULE2 RULE14
          state_d = ST_DONE;
        end else if (secondStrobe && zeroesSeen_q) begin
          state_d = ST_DONE; // RULE7 RULE15
        end
      end
      ST_DONE: begin
        timer_d = timer_q;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // saturating count: later shift strobes never look like a handshake
    if (strobeFall && strobeCnt_q != 2'h2) begin
      strobeCnt_d = strobeCnt_q + 2'h1;
    end
    // an aux flag already seen masks the clear, so data never rises
    if (firstStrobe && !auxSeen_q) begin
      zeroesPending_d = 1'b0; // RULE13 RULE5 RULE3
    end
    // a detect in the same cycle as the clear wins
    if (zeroesDetect && state_q == ST_COLLECT && !zeroesSeen_q) begin
      zeroesPending_d = 1'b1;
      zeroesSeen_d = 1'b1;
    end
    if (rearm) begin
      state_d = ST_IDLE;
      zeroesPending_d = 1'b0;
      zeroesSeen_d = 1'b0;
      auxSeen_d = 1'b0;
      strobeCnt_d = 2'h0;
      timer_d = 32'h0;
    end
  end

  always_comb begin
    buf_d = buf_q;
    ptr_d = ptr_q;
    for (int t = 0; t < TRACKS; t++) begin
      if (state_q == ST_IDLE && wakeup) begin
        ptr_d[t] = '0;
        buf_d[t] = '0;
      end else if (state_q == ST_COLLECT && trackEn[t] && bitValid[t] && !full[t]) begin
        // noisy slow tracks may store junk here; the host must filter it
        buf_d[t][ptr_q[t]] = bitIn[t]; // RULE8 RULE10
        ptr_d[t] = ptr_q[t] + PW'(1);
      end
    end
  end

  always_comb begin
    // any pending flag, the aux flag or a stopped buffer pulls the line low
    if (state_d == ST_IDLE) begin
      dataLine_d = stripe_pkg::LINE_IDLE;
    end else if (state_d == ST_DONE) begin
      dataLine_d = 1'b0; // RULE4 RULE5 RULE15 RULE16
    end else begin
      dataLine_d = ~zeroesPending_d; // RULE13 RULE3
    end
    // registered read keeps the wide buffer mux off the output path
    rdBit_d = buf_q[rdTrack][rdIdx];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      zeroesPending_q <= 1'b0;
      zeroesSeen_q <= 1'b0;
      auxSeen_q <= 1'b0;
      strobeCnt_q <= 2'h0;
      timer_q <= 32'h0;
    end else begin
      state_q <= state_d;
      zeroesPending_q <= zeroesPending_d;
      zeroesSeen_q <= zeroesSeen_d;
      auxSeen_q <= auxSeen_d;
      strobeCnt_q <= strobeCnt_d;
      timer_q <= timer_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      buf_q <= '0;
      ptr_q <= '0;
    end else begin
      buf_q <= buf_d;
      ptr_q <= ptr_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dataLine_q <= stripe_pkg::LINE_IDLE;
      rdBit_q <= 1'b0;
    end else begin
      dataLine_q <= dataLine_d;
      rdBit_q <= rdBit_d;
    end
  end

  assign link.dataLine = dataLine_q;
  assign rdBit = rdBit_q;
  assign collecting = (state_q == ST_COLLECT);
  assign bufferReady = (state_q == ST_DONE);
  assign trackFull = full;
endmodule

// ### src/stripe_host.sv
module stripe_host (
  input wire logic mclk,
  input wire logic rst,
  stripe_link_if.host link,
  input wire logic start,
  input wire logic waitAux,
  input wire logic extSwitch,
  output logic busy,
  output logic auxAssumed,
  output logic zeroesCleared,
  output logic handshakeDone
);
  typedef enum logic [6:0] {
    H_IDLE = 7'b0000001,
    H_WAIT = 7'b0000010,
    H_CLR_LOW = 7'b0000100,
    H_CLR_HIGH = 7'b0001000,
    H_AUX_WAIT = 7'b0010000,
    H_STOP_LOW = 7'b0100000,
    H_STOP_HIGH = 7'b1000000
  } host_state_e;

  host_state_e state_q, state_d;
  logic [stripe_pkg::TIMER_W-1:0] timer_q, timer_d;
  logic strobeN_q, strobeN_d;
  logic auxAssumed_q, auxAssumed_d;
  logic cleared_q, cleared_d;
  logic done_q, done_d;
  logic dataLevel, dataFall, timerEnd;
  logic [stripe_pkg::TIMER_W-1:0] limit;

  sync_fall u_data_sync (
    .mclk(mclk),
    .rst(rst),
    .pinIn(link.dataLine),
    .level(dataLevel),
    .fall(dataFall)
  );

  always_comb begin
    case (state_q)
      H_CLR_LOW: limit = stripe_pkg::TIMER_W'(stripe_pkg::CLEAR_LOW_CYC);
      H_CLR_HIGH: limit = stripe_pkg::TIMER_W'(stripe_pkg::FLAG_CLEAR_CYC);
      H_STOP_LOW: limit = stripe_pkg::TIMER_W'(stripe_pkg::STOP_LOW_CYC);
      default: limit = stripe_pkg::TIMER_W'(stripe_pkg::STROBE_HIGH_CYC);
    endcase
  end
  assign timerEnd = (timer_q == limit - stripe_pkg::TIMER_W'(1));

  always_comb begin
    state_d = state_q;
    timer_d = timer_q + stripe_pkg::TIMER_W'(1);
    auxAssumed_d = auxAssumed_q;
    cleared_d = cleared_q;
    done_d = 1'b0;
    case (state_q)
      H_IDLE: begin
        timer_d = '0;
        if (start) begin
          state_d = H_WAIT;
          auxAssumed_d = 1'b0;
          cleared_d = 1'b0;
        end
      end
      H_WAIT: begin
        timer_d = '0;
        // the first strobe goes out whichever flag showed
        if (dataFall || extSwitch) begin
          state_d = H_CLR_LOW; // RULE1 RULE3
        end
      end
      H_CLR_LOW: begin
        if (timerEnd) begin
          state_d = H_CLR_HIGH;
          timer_d = '0;
        end
      end
      H_CLR_HIGH: begin
        // flag-clear wait also covers the least high time before the stop
        if (timerEnd) begin
          timer_d = '0;
          if (!dataLevel) begin
            auxAssumed_d = 1'b1; // RULE6
            state_d = H_STOP_LOW; // RULE4
          end else begin
            cleared_d = 1'b1;
            state_d = waitAux ? H_AUX_WAIT : H_STOP_LOW; // RULE11
          end
        end
      end
      H_AUX_WAIT: begin
        timer_d = '0;
        if (dataFall || extSwitch) begin
          state_d = H_STOP_LOW; // RULE12
        end
      end
      H_STOP_LOW: begin
        if (timerEnd) begin
          state_d = H_STOP_HIGH;
          timer_d = '0;
        end
      end
      H_STOP_HIGH: begin
        if (timerEnd) begin
          state_d = H_IDLE;
          done_d = 1'b1; // RULE1
        end
      end
      default: begin
        state_d = H_IDLE;
      end
    endcase
    strobeN_d = ~(state_d == H_CLR_LOW || state_d == H_STOP_LOW);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= H_IDLE;
      timer_q <= '0;
      strobeN_q <= 1'b1;
      auxAssumed_q <= 1'b0;
      cleared_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      strobeN_q <= strobeN_d;
      auxAssumed_q <= auxAssumed_d;
      cleared_q <= cleared_d;
      done_q <= done_d;
    end
  end

  assign link.strobeN = strobeN_q;
  assign busy = (state_q != H_IDLE);
  assign auxAssumed = auxAssumed_q;
  assign zeroesCleared = cleared_q;
  assign handshakeDone = done_q;
endmodule

// ### dv/stripe_checker.sv
module stripe_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic strobeN,
  input wire logic dataLine
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] falls_q, falls_d, dFalls_q, dFalls_d;
  logic [11:0] lowCnt_q, lowCnt_d, highCnt_q, highCnt_d;
  logic [7:0] since_q, since_d;
  logic cleared_q, cleared_d, sPrev_q, sPrev_d, dPrev_q, dPrev_d;

  // counts saturate so a long wait cannot wrap round into a passing value
  always_comb begin
    falls_d = falls_q;
    dFalls_d = dFalls_q;
    since_d = (since_q == 8'hff) ? since_q : since_q + 8'h1;
    lowCnt_d = strobeN ? 12'h0 : ((lowCnt_q == 12'hfff) ? lowCnt_q : lowCnt_q + 12'h1);
    highCnt_d = !strobeN ? 12'h0 : ((highCnt_q == 12'hfff) ? highCnt_q : highCnt_q + 12'h1);
    cleared_d = cleared_q | (dataLine & ~dPrev_q & (falls_q != 2'h0));
    sPrev_d = strobeN;
    dPrev_d = dataLine;
    if (sPrev_q && !strobeN) begin
      since_d = 8'h0;
      if (falls_q != 2'h3) falls_d = falls_q + 2'h1;
    end
    if (dPrev_q && !dataLine && dFalls_q != 2'h3) dFalls_d = dFalls_q + 2'h1;
    if (rst) begin
      {falls_d, dFalls_d, lowCnt_d, highCnt_d, cleared_d} = '0;
      since_d = 8'hff;
      sPrev_d = 1'b1;
      dPrev_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    {falls_q, dFalls_q, lowCnt_q, highCnt_q} <= {falls_d, dFalls_d, lowCnt_d, highCnt_d};
    {since_q, cleared_q, sPrev_q, dPrev_q} <= {since_d, cleared_d, sPrev_d, dPrev_d};
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_reset_idle: assert property ($past(rst) |-> strobeN && dataLine)
    else $error("link not idle after reset");
  a_strobe_limit: assert property ($fell(strobeN) |-> falls_q < 2'h2)
    else $error("more than two handshake strobes");
  a_clear_width: assert property ($rose(strobeN) && falls_q == 2'h1 |->
    lowCnt_q >= stripe_pkg::CLEAR_LOW_CYC) else $error("first strobe too short");
  a_stop_width: assert property ($rose(strobeN) && falls_q == 2'h2 |->
    lowCnt_q >= stripe_pkg::STOP_LOW_CYC) else $error("stop strobe too short");
  a_strobe_gap: assert property ($fell(strobeN) && falls_q == 2'h1 |->
    highCnt_q >= stripe_pkg::STROBE_HIGH_CYC) else $error("strobe gap too short");
  a_stop_ready: assert property ($fell(strobeN) && falls_q == 2'h1 && cleared_q
    && dataLine |-> ##[1:8] !dataLine) else $error("stop strobe did not end collection");
  a_clear_rise: assert property ($rose(dataLine) |-> falls_q == 2'h1 && since_q <= 8'h8)
    else $error("data rose outside the clear strobe");
  a_done_holds: assert property (falls_q == 2'h2 && !dataLine |=> !dataLine)
    else $error("data left ready state");
  a_single_aux: assert property ($fell(dataLine) |-> dFalls_q < 2'h2)
    else $error("too many data falls");

  c_clear: cover property ($rose(dataLine));
  c_stop: cover property ($fell(strobeN) && falls_q == 2'h1 && cleared_q && dataLine);
  c_ready: cover property (falls_q == 2'h2 && !dataLine);
endmodule

// ### dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic aux; logic clr; logic col; logic rdy;} note_s;
  logic mclk = 1'b0, rst = 1'b1, wakeup = 1'b0, rearm = 1'b0, zeroesDetect = 1'b0;
  logic start = 1'b0, waitAux = 1'b0, extSwitch = 1'b0;
  logic [2:0] trackEn = 3'h7, ampLost = 3'h0, bitValid = 3'h0, bitIn = 3'h0;
  logic [1:0] rdTrack = 2'h0;
  logic [9:0] rdIdx = 10'h0;
  logic rdBit, collecting, bufferReady, busy, auxAssumed, zeroesCleared, handshakeDone;
  logic [2:0] trackFull;
  logic [31:0] seed = 32'h9d9f;
  int nFail = 0, compares = 0;
  note_s q[$];
  note_s got;

  assign got = {auxAssumed, zeroesCleared, collecting, bufferReady};

  always #2.5 mclk = ~mclk;

  stripe_link_if stripe_link_if_i ();
  // short swipe timeout; the extSwitch case must finish its handshake before it
  stripe_device #(.AUX_TIMEOUT_CYC(4000)) stripe_device_i (.mclk(mclk), .rst(rst),
    .link(stripe_link_if_i), .trackEn(trackEn), .wakeup(wakeup), .rearm(rearm),
    .zeroesDetect(zeroesDetect), .ampLost(ampLost), .bitValid(bitValid), .bitIn(bitIn),
    .rdTrack(rdTrack), .rdIdx(rdIdx), .rdBit(rdBit), .collecting(collecting),
    .bufferReady(bufferReady), .trackFull(trackFull));
  stripe_host stripe_host_i (.mclk(mclk), .rst(rst), .link(stripe_link_if_i), .start(start),
    .waitAux(waitAux), .extSwitch(extSwitch), .busy(busy), .auxAssumed(auxAssumed),
    .zeroesCleared(zeroesCleared), .handshakeDone(handshakeDone));
  stripe_checker stripe_checker_i (.mclk(mclk), .rst(rst),
    .strobeN(stripe_link_if_i.strobeN), .dataLine(stripe_link_if_i.dataLine));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    compares++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic waitHi(input logic cleared, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge mclk);
      if ((cleared ? zeroesCleared : handshakeDone) === 1'b1) break;
    end
    if (i == n) chk("wait", 4'h1, 4'h0);
  endtask

  task automatic printVerdict();
    $display("compares %0d mismatches %0d", compares, nFail);
    if (nFail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    if (handshakeDone === 1'b1) begin
      if (q.size() == 0) begin
        chk("spare done", 4'h0, 4'hf);
      end else begin
        chk("handshake", q.pop_front(), got);
        chk("idle after", 4'h0, {3'h0, busy});
      end
    end
  end

  task automatic arm(input note_s exp);
    rst <= 1'b1;
    ampLost <= 3'h0;
    step(2);
    rst <= 1'b0;
    step(4);
    q.push_back(exp);
    wakeup <= 1'b1;
    start <= 1'b1;
    step(1);
    wakeup <= 1'b0;
    start <= 1'b0;
    step(4);
  endtask

  // amp: 0 none, 1 with the zeroes flag, 2 once the flag is cleared
  task automatic run(input logic zer, input logic [1:0] amp, input logic ext, input note_s exp);
    waitAux <= (amp == 2'h2);
    arm(exp);
    chk("busy", 4'h1, {3'h0, busy});
    zeroesDetect <= zer;
    extSwitch <= ext;
    if (amp == 2'h1) ampLost <= 3'h7;
    step(1);
    zeroesDetect <= 1'b0;
    extSwitch <= 1'b0;
    if (amp == 2'h2) begin
      waitHi(1'b1, 2000);
      ampLost <= 3'h7;
    end
    waitHi(1'b0, 9000);
    // stop was ignored, so the device stays in collection until a rearm or the swipe timeout
    if (ext) begin
      rearm <= 1'b1;
      step(1);
      rearm <= 1'b0;
      step(2);
      chk("rearm", 4'h1, {1'b0, collecting, bufferReady, stripe_link_if_i.dataLine});
    end
  endtask

  initial begin
    logic [31:0] r;
    logic [2:0] en, b0, bl;
    run(1'b1, 2'h0, 1'b0, 4'b0101);
    run(1'b1, 2'h2, 1'b0, 4'b0101);
    run(1'b0, 2'h0, 1'b0, 4'b1001);
    run(1'b1, 2'h1, 1'b0, 4'b1001);
    run(1'b0, 2'h0, 1'b1, 4'b0110);
    waitAux <= 1'b0;
    r = rnd();
    en = r[2:0] | 3'h1;
    trackEn <= en;
    arm(4'b1001);
    for (int i = 0; i < 609; i++) begin
      r = rnd();
      bitValid <= 3'h7;
      bitIn <= r[2:0];
      if (i == 0) b0 = r[2:0];
      if (i == 607) bl = r[2:0];
      step(1);
    end
    bitValid <= 3'h0;
    waitHi(1'b0, 9000);
    chk("trackFull", {1'b0, en}, {1'b0, trackFull});
    for (int t = 0; t < 3; t++) begin
      if (en[t]) begin
        rdTrack <= t[1:0];
        rdIdx <= 10'h0;
        step(2);
        chk("first bit", {3'h0, b0[t]}, {3'h0, rdBit});
        rdIdx <= 10'h25f;
        step(2);
        chk("last bit", {3'h0, bl[t]}, {3'h0, rdBit});
      end
    end
    printVerdict();
  end

  initial begin
    #400000;
    nFail++;
    printVerdict();
  end
endmodule
